// >>> rtl/led_cfg_pkg.sv
package led_cfg_pkg;

  // Register byte addresses on the APB port
  localparam logic [7:0] OFS_FIRST_HI  = 8'h00; // First word bits 47..32
  localparam logic [7:0] OFS_SECOND_LO = 8'h04; // Second word bits 31..0
  localparam logic [7:0] OFS_SECOND_HI = 8'h08; // Second word bits 47..32
  localparam logic [7:0] OFS_PANEL_ST  = 8'h0C; // Decoded panel layout, read only

  // First word: only bits 47..40 live in this block
  localparam int FIRST_LSB    = 40;
  localparam int GRN_TOL_BIT  = 40;
  localparam int BLU_TOL_BIT  = 41;
  localparam int SUBP_CAP_BIT = 42;
  localparam int PANEL_LSB    = 43;
  localparam int PANEL_W      = 3;
  localparam int PSAVE_BIT    = 47;
  localparam logic [7:0]  FIRST_RST  = 8'h3B;
  localparam logic [47:0] SECOND_RST = 48'h003B_7F7F_7F00;

  // Second word field positions and widths
  localparam int RED_OPEN_LSB  = 0;
  localparam int GRN_OPEN_LSB  = 2;
  localparam int BLU_OPEN_LSB  = 4;
  localparam int OPEN_W        = 2;
  localparam int READBACK_BIT  = 7;
  localparam int RED_LVL_LSB   = 8;
  localparam int GRN_LVL_LSB   = 16;
  localparam int BLU_LVL_LSB   = 24;
  localparam int LVL_W         = 8;
  localparam int GLOBAL_LSB    = 32;
  localparam int GLOBAL_W      = 3;
  localparam int REMOVAL_LSB   = 35;
  localparam int REMOVAL_W     = 4;
  localparam int RED_SHORT_LSB = 39;
  localparam int GRN_SHORT_LSB = 42;
  localparam int BLU_SHORT_LSB = 45;
  localparam int SHORT_W       = 3;

  // Subperiod ceiling while the cap is on
  localparam logic [8:0] SUBP_CAP = 9'h100;

  // Panel arrangement codes, in code order 000b..111b
  typedef enum logic [2:0] {
    PANEL_16, PANEL_32, PANEL_48_123, PANEL_48_132,
    PANEL_4864_123, PANEL_4864_132, PANEL_64_1234, PANEL_64_1423
  } panel_e;

  // Decoded panel layout; order holds 0-based device index per scan slot
  typedef struct packed {
    logic [6:0] cols;
    logic [6:0] rows;
    logic [2:0] devices;
    logic [3:0] rev;
    logic [7:0] order;
  } panel_s;

  localparam panel_s PANEL_RST = '{7'h40, 7'h40, 3'h4, 4'hC, 8'h9C};

endpackage : led_cfg_pkg

// >>> rtl/word_if.sv
`timescale 1ns/1ns
// Write port and stored value of one configuration word
interface word_if #(parameter int W = 8) ();
  logic         we; // Commit strobe
  logic [W-1:0] wd; // Full next word
  logic [W-1:0] q;  // Stored word
  modport ctl   (output we, wd, input q);
  modport store (input we, wd, output q);
endinterface : word_if

// >>> rtl/cfg_store.sv
`timescale 1ns/1ns
// One read-write configuration word with its reset value
module cfg_store #(
  parameter int           W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input logic   pclk,
  input logic   presetn,
  // Word port
  word_if.store w
);

  logic [W-1:0] d; // Next stored value

  // Hold unless a write commits
  always_comb begin
    d = w.we ? w.wd : w.q;
  end

  // Storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w.q <= RST;
    end else begin
      w.q <= d;
    end
  end

endmodule : cfg_store

// >>> rtl/panel_decode.sv
`timescale 1ns/1ns
// Turns the arrangement code into device count, reversal and scan order
module panel_decode
  import led_cfg_pkg::*;
(
  // Clock and reset
  input  logic       pclk,
  input  logic       presetn,
  // Arrangement code in, layout out (registered)
  input  logic [2:0] code,
  output panel_s     layout_q
);

  panel_s layout_d; // Decoded layout

  // One entry per code; order slots run D1 first
  always_comb begin
    case (panel_e'(code))
      PANEL_16:       layout_d = '{7'h10, 7'h10, 3'h1, 4'h0, 8'h00};
      PANEL_32:       layout_d = '{7'h20, 7'h20, 3'h2, 4'h0, 8'h04};
      PANEL_48_123:   layout_d = '{7'h30, 7'h30, 3'h3, 4'h4, 8'h24};
      PANEL_48_132:   layout_d = '{7'h30, 7'h30, 3'h3, 4'h4, 8'h18};
      PANEL_4864_123: layout_d = '{7'h30, 7'h40, 3'h4, 4'hC, 8'h24};
      PANEL_4864_132: layout_d = '{7'h30, 7'h40, 3'h4, 4'hC, 8'h18};
      // Ambiguous listing; plain 1-2-3-4 order taken
      PANEL_64_1234:  layout_d = '{7'h40, 7'h40, 3'h4, 4'hC, 8'hE4};
      default:        layout_d = '{7'h40, 7'h40, 3'h4, 4'hC, 8'h9C};
    endcase
  end

  // Registered so every top output comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      layout_q <= PANEL_RST;
    end else begin
      layout_q <= layout_d;
    end
  end

endmodule : panel_decode

// >>> rtl/led_driver_display_config_regs.sv
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ns
// Notes on behaviour
// - Bit 41 blue tolerance, 1 low, resets 1
// - Bit 42 caps subperiod count at 256
// - Bits 45-43 arrangement; 000 16x16, 001 32x32
// - Code 010 48x48 D3 reversed, order 1-2-3
// - Codes 100/101 48x64, orders 1-2-3 / 1-3-2
// - Codes 110/111 64x64; 111 order 1-4-2-3
// - Bit 47 power save enable, resets 0
// - Open thresholds at bits 1-0, 3-2, 5-4
// - Bit 7 enables fault result readback
// - Colour levels 15-8, 23-16, 31-24, reset 127
// - Global level bits 34-32, reset 3
// - Short removal level is code plus one
// - Short thresholds at 41-39, 44-42, 47-45
// - Bit 40 green tolerance, 1 low, resets 1
module led_driver_display_config_regs
  import led_cfg_pkg::*;
(
  // Clock and reset
  input  logic        pclk,
  input  logic        presetn,
  // APB slave
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // First word controls
  output logic        blue_group_noise_tolerance,
  output logic        green_group_noise_tolerance,
  output logic        subperiod_cap_enable,
  output logic [8:0]  subperiod_limit,
  output logic [2:0]  panel_arrangement_select,
  output logic        matrix_power_save_enable,
  // Decoded panel layout
  output logic [6:0]  panel_cols,
  output logic [6:0]  panel_rows,
  output logic [2:0]  panel_devices,
  output logic [3:0]  panel_reversed,
  output logic [7:0]  panel_scan_order,
  // Second word controls
  output logic [1:0]  red_open_threshold,
  output logic [1:0]  green_open_threshold,
  output logic [1:0]  blue_open_threshold,
  output logic        fault_result_readback_enable,
  output logic [7:0]  red_colour_level,
  output logic [7:0]  green_colour_level,
  output logic [7:0]  blue_colour_level,
  output logic [2:0]  global_level,
  output logic [4:0]  short_removal_level,
  output logic [2:0]  red_short_threshold,
  output logic [2:0]  green_short_threshold,
  output logic [2:0]  blue_short_threshold
);

  // Stored words
  word_if #(.W(8))  first_w ();  // Bits 47..40 of the first word
  word_if #(.W(48)) second_w (); // Whole second word

  panel_s      layout_q;   // Decoded arrangement
  logic        pready_q;   // Answer strobe
  logic        pready_d;
  logic [31:0] prdata_q;   // Read data, valid with pready
  logic [31:0] prdata_d;
  logic        pslverr_q;  // Unmapped address flag
  logic        pslverr_d;
  logic [8:0]  subp_q;     // Registered subperiod ceiling
  logic [8:0]  subp_d;
  logic [4:0]  removal_q;  // Registered short removal level
  logic [4:0]  removal_d;
  logic        acc_first;  // First access cycle of a transfer
  logic        wr_go;      // Write commits at this edge
  logic        sel_first;  // Address decode
  logic        sel_lo;
  logic        sel_hi;
  logic        sel_st;
  logic        hit;
  logic [31:0] rd_mux;     // Read data before registering

  // Reset level follows the stored reset code, plus one
  localparam logic [4:0] REMOVAL_RST = {1'b0, SECOND_RST[REMOVAL_LSB +: REMOVAL_W]} + 5'h01;

  // Address decode, priority chain
  always_comb begin
    sel_first = 1'b0;
    sel_lo    = 1'b0;
    sel_hi    = 1'b0;
    sel_st    = 1'b0;
    if (paddr == OFS_FIRST_HI) begin
      sel_first = 1'b1;
    end else if (paddr == OFS_SECOND_LO) begin
      sel_lo = 1'b1;
    end else if (paddr == OFS_SECOND_HI) begin
      sel_hi = 1'b1;
    end else if (paddr == OFS_PANEL_ST) begin
      sel_st = 1'b1;
    end
    hit = sel_first | sel_lo | sel_hi | sel_st;
  end

  // Read mux; lower fields of the first word belong elsewhere, read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_first) begin
      rd_mux = {16'h0000, first_w.q, 8'h00};
    end else if (sel_lo) begin
      rd_mux = second_w.q[31:0];
    end else if (sel_hi) begin
      rd_mux = {16'h0000, second_w.q[47:32]};
    end else if (sel_st) begin
      rd_mux = {3'h0, layout_q};
    end
  end

  // One wait state: pready rises on the second access cycle, so read data
  // is taken from a flop and the write lands on the pready edge only.
  assign acc_first = psel && penable && !pready_q;
  assign wr_go     = psel && penable && pwrite && pready_q;

  // First word write path; reserved bit 46 is stored as written
  assign first_w.we = wr_go && sel_first;
  assign first_w.wd = pwdata[15:8];

  // Second word write path; each half merges with the other half held
  assign second_w.we = wr_go && (sel_lo || sel_hi);
  assign second_w.wd = sel_lo ? {second_w.q[47:32], pwdata}
                              : {pwdata[15:0], second_w.q[31:0]};

  // Storage for both words
  cfg_store #(.W(8), .RST(FIRST_RST)) first_store (
    .pclk    (pclk),
    .presetn (presetn),
    .w       (first_w)
  );

  cfg_store #(.W(48), .RST(SECOND_RST)) second_store (
    .pclk    (pclk),
    .presetn (presetn),
    .w       (second_w)
  );

  // Arrangement decoder
  panel_decode layout_dec (
    .pclk     (pclk),
    .presetn  (presetn),
    .code     (first_w.q[PANEL_LSB-FIRST_LSB +: PANEL_W]),
    .layout_q (layout_q)
  );

  // Bus answer and subperiod ceiling, next values
  always_comb begin
    pready_d  = acc_first;
    prdata_d  = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (acc_first) begin
      // Writes return zero data; errors only for unmapped addresses
      prdata_d  = pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_d = !hit;
    end
    // Zero means no ceiling
    if (first_w.q[SUBP_CAP_BIT-FIRST_LSB]) begin
      subp_d = SUBP_CAP;
    end else begin
      subp_d = 9'h000;
    end
    // Level kept in its own flop so the port is registered, not an adder
    removal_d = removal_q;
    if (second_w.we) begin
      removal_d = {1'b0, second_w.wd[REMOVAL_LSB +: REMOVAL_W]} + 5'h01;
    end
  end

  // Bus answer and subperiod ceiling, registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      subp_q    <= 9'h000;
      removal_q <= REMOVAL_RST;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
      subp_q    <= subp_d;
      removal_q <= removal_d;
    end
  end

  // Bus outputs
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // First word controls; all but the subperiod limit straight from storage
  assign green_group_noise_tolerance = first_w.q[GRN_TOL_BIT-FIRST_LSB];
  assign blue_group_noise_tolerance  = first_w.q[BLU_TOL_BIT-FIRST_LSB];
  assign subperiod_cap_enable        = first_w.q[SUBP_CAP_BIT-FIRST_LSB];
  assign subperiod_limit             = subp_q;
  assign panel_arrangement_select    = first_w.q[PANEL_LSB-FIRST_LSB +: PANEL_W];
  assign matrix_power_save_enable    = first_w.q[PSAVE_BIT-FIRST_LSB];

  // Decoded layout
  assign panel_cols       = layout_q.cols;
  assign panel_rows       = layout_q.rows;
  assign panel_devices    = layout_q.devices;
  assign panel_reversed   = layout_q.rev;
  assign panel_scan_order = layout_q.order;

  // Second word controls
  assign red_open_threshold   = second_w.q[RED_OPEN_LSB +: OPEN_W];
  assign green_open_threshold = second_w.q[GRN_OPEN_LSB +: OPEN_W];
  assign blue_open_threshold  = second_w.q[BLU_OPEN_LSB +: OPEN_W];
  assign fault_result_readback_enable = second_w.q[READBACK_BIT];
  assign red_colour_level     = second_w.q[RED_LVL_LSB +: LVL_W];
  assign green_colour_level   = second_w.q[GRN_LVL_LSB +: LVL_W];
  assign blue_colour_level    = second_w.q[BLU_LVL_LSB +: LVL_W];
  assign global_level         = second_w.q[GLOBAL_LSB +: GLOBAL_W];
  // Code 0 means level 1; the sum is formed on the write path
  assign short_removal_level  = removal_q;
  assign red_short_threshold   = second_w.q[RED_SHORT_LSB +: SHORT_W];
  assign green_short_threshold = second_w.q[GRN_SHORT_LSB +: SHORT_W];
  assign blue_short_threshold  = second_w.q[BLU_SHORT_LSB +: SHORT_W];

  // Checks on the design's own outputs
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Committing writes per register
  sequence wr_first_s;
    psel && penable && pwrite && pready_q && paddr == OFS_FIRST_HI;
  endsequence

  sequence wr_lo_s;
    psel && penable && pwrite && pready_q && paddr == OFS_SECOND_LO;
  endsequence

  sequence wr_hi_s;
    psel && penable && pwrite && pready_q && paddr == OFS_SECOND_HI;
  endsequence

  // Read taken at the pready edge
  sequence rd_lo_s;
    psel && penable && !pwrite && pready_q && paddr == OFS_SECOND_LO;
  endsequence

  // Arrangement code stable for two cycles
  sequence code_held_s(logic [2:0] c);
    panel_arrangement_select == c ##1 panel_arrangement_select == c;
  endsequence

  blue_tol_wr_a: assert property (
    wr_first_s |=> blue_group_noise_tolerance == $past(pwdata[9])
  ) else $error("blue tolerance bit not taken from write");

  green_tol_wr_a: assert property (
    wr_first_s |=> green_group_noise_tolerance == $past(pwdata[8])
  ) else $error("green tolerance bit not taken from write");

  subp_cap_a: assert property (
    wr_first_s ##1 subperiod_cap_enable |=> subperiod_limit == 9'h100
  ) else $error("subperiod ceiling not 256 after cap set");

  power_save_wr_a: assert property (
    wr_first_s |=> matrix_power_save_enable == $past(pwdata[15])
  ) else $error("power save bit not taken from write");

  panel_small_a: assert property (
    code_held_s(3'h0) |-> panel_rows == 7'h10 && panel_devices == 3'h1
  ) else $error("16x16 layout not decoded");

  panel_48_a: assert property (
    code_held_s(3'h2) |-> panel_reversed == 4'h4 && panel_scan_order == 8'h24
  ) else $error("48x48 layout not decoded");

  panel_4864_a: assert property (
    code_held_s(3'h5) |-> panel_rows == 7'h40 && panel_scan_order == 8'h18
  ) else $error("48x64 one-three-two layout not decoded");

  panel_64_a: assert property (
    code_held_s(3'h7) |-> panel_reversed == 4'hC && panel_scan_order == 8'h9C
  ) else $error("64x64 layout not decoded");

  lo_fields_wr_a: assert property (
    wr_lo_s |=> green_colour_level == $past(pwdata[23:16])
            && blue_open_threshold == $past(pwdata[5:4])
            && fault_result_readback_enable == $past(pwdata[7])
  ) else $error("second word low fields not taken from write");

  removal_wr_a: assert property (
    wr_hi_s |=> short_removal_level == {1'b0, $past(pwdata[6:3])} + 5'h01
            && global_level == $past(pwdata[2:0])
            && blue_short_threshold == $past(pwdata[15:13])
  ) else $error("second word high fields wrong after write");

  readback_lo_a: assert property (
    rd_lo_s |-> pready && prdata == second_w.q[31:0]
  ) else $error("second word low readback differs from store");

  ready_pulse_a: assert property (
    psel && penable && !pready |=> pready ##1 !pready
  ) else $error("pready not a single pulse after one wait");

endmodule : led_driver_display_config_regs

// >>> verif/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the display configuration registers
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t mismatch got %0h exp %0h", $time, g, e); end end
module tb_top;
  // Clock, reset and APB
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  // Configuration outputs
  logic        blu_tol, grn_tol, cap_en, psave, rb_en;
  logic [8:0]  sub_lim;
  logic [2:0]  arr, glob, r_sh, g_sh, b_sh, p_dev;
  logic [6:0]  p_cols, p_rows;
  logic [3:0]  p_rev;
  logic [7:0]  p_ord, r_lvl, g_lvl, b_lvl;
  logic [1:0]  r_op, g_op, b_op;
  logic [4:0]  rm_lvl;
  // Reference model: first word bits 47..40 and the whole second word
  logic [7:0]  fw;
  logic [47:0] sw;
  int          err_count, check_count;
  // Panel layout per arrangement code; scan slots past the device count are unspecified
  int cols_t[8] = '{16, 32, 48, 48, 48, 48, 64, 64};
  int rows_t[8] = '{16, 32, 48, 48, 64, 64, 64, 64};
  int dev_t[8]  = '{1, 2, 3, 3, 4, 4, 4, 4};
  int rev_t[8]  = '{0, 0, 4, 4, 12, 12, 12, 12};
  int ord_t[8]  = '{0, 0, 'h24, 'h18, 'h24, 'h18, 'hE4, 'h9C};
  int om_t[8]   = '{0, 0, 'h3F, 'h3F, 'hFF, 'hFF, 'hFF, 'hFF};

  led_driver_display_config_regs dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .blue_group_noise_tolerance(blu_tol), .green_group_noise_tolerance(grn_tol),
    .subperiod_cap_enable(cap_en), .subperiod_limit(sub_lim),
    .panel_arrangement_select(arr), .matrix_power_save_enable(psave),
    .panel_cols(p_cols), .panel_rows(p_rows), .panel_devices(p_dev),
    .panel_reversed(p_rev), .panel_scan_order(p_ord),
    .red_open_threshold(r_op), .green_open_threshold(g_op), .blue_open_threshold(b_op),
    .fault_result_readback_enable(rb_en), .red_colour_level(r_lvl),
    .green_colour_level(g_lvl), .blue_colour_level(b_lvl), .global_level(glob),
    .short_removal_level(rm_lvl), .red_short_threshold(r_sh),
    .green_short_threshold(g_sh), .blue_short_threshold(b_sh)
  );

  // Free-running 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // Expected read value; the status word packs the decoded layout
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    int c;
    c = fw[5:3];
    case (a)
      8'h00:   exp_rd = {16'h0, fw, 8'h00};
      8'h04:   exp_rd = sw[31:0];
      8'h08:   exp_rd = {16'h0, sw[47:32]};
      8'h0C:   exp_rd = {3'h0, 7'(cols_t[c]), 7'(rows_t[c]), 3'(dev_t[c]), 4'(rev_t[c]),
                         8'(ord_t[c])};
      default: exp_rd = 32'h0;
    endcase
  endfunction : exp_rd

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_count++;
      final_report();
    end
  endtask : apb

  // Write and update the model; the status word ignores writes
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
    `CHK(er, (a > 8'h0C || a[1:0] != 2'b00))
    if (a == 8'h00) fw = d[15:8];
    if (a == 8'h04) sw[31:0] = d;
    if (a == 8'h08) sw[47:32] = d[15:0];
  endtask : wr_reg

  // Read back and compare, masking scan slots that the layout leaves open
  task automatic rd_reg(input logic [7:0] a);
    logic [31:0] rd, m;
    logic        er;
    m = (a == 8'h0C) ? {24'hFFFFFF, 8'(om_t[fw[5:3]])} : 32'hFFFFFFFF;
    apb(1'b0, a, 32'h0, rd, er);
    `CHK(er, (a > 8'h0C))
    `CHK(rd & m, exp_rd(a) & m)
  endtask : rd_reg

  // Hold reset for four clocks; the model returns to values worked out field by field
  task automatic do_reset;
    presetn <= 1'b0;
    fw = {1'b0, 1'b0, 3'b111, 1'b0, 1'b1, 1'b1};
    sw = {9'h000, 4'b0111, 3'b011, 8'd127, 8'd127, 8'd127, 8'h00};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // Let the decode stage settle, then check every output and every register
  task automatic check_all;
    int c;
    repeat (2) @(posedge pclk);
    #1;
    c = fw[5:3];
    `CHK(blu_tol, fw[1])
    `CHK(grn_tol, fw[0])
    `CHK(cap_en, fw[2])
    `CHK(sub_lim, (fw[2] ? 9'h100 : 9'h000))
    `CHK(arr, fw[5:3])
    `CHK({p_cols, p_rows}, {7'(cols_t[c]), 7'(rows_t[c])})
    `CHK({p_dev, p_rev}, {3'(dev_t[c]), 4'(rev_t[c])})
    `CHK(p_ord & 8'(om_t[c]), 8'(ord_t[c]))
    `CHK(psave, fw[7])
    `CHK({b_op, g_op, r_op}, sw[5:0])
    `CHK(rb_en, sw[7])
    `CHK({b_lvl, g_lvl, r_lvl}, sw[31:8])
    `CHK(glob, sw[34:32])
    `CHK(rm_lvl, {1'b0, sw[38:35]} + 5'd1)
    `CHK({b_sh, g_sh, r_sh}, sw[47:39])
    rd_reg(8'h00);
    rd_reg(8'h04);
    rd_reg(8'h08);
    rd_reg(8'h0C);
  endtask : check_all

  // Main sequence
  initial begin
    logic [7:0] a;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr  = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    check_count = 0;
    // Seed once, before any test
    void'($urandom(37));
    do_reset();
    check_all();
    // Every arrangement code, with the cap and power save toggled along
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'h00, {16'hFFFF, 1'(c), 1'b0, 3'(c), 1'(c >> 1), 2'b00, 8'hFF});
      check_all();
    end
    // Unmapped and unaligned addresses refuse; writes to the status word are dropped
    wr_reg(8'h10, 32'hFFFF_FFFF);
    wr_reg(8'h06, 32'hFFFF_FFFF);
    wr_reg(8'h0C, 32'hFFFF_FFFF);
    rd_reg(8'h10);
    check_all();
    // Random traffic over the three writable places, extreme codes included
    for (int i = 0; i < 24; i++) begin
      a = 8'(($urandom % 3) * 4);
      wr_reg(a, (i < 2) ? {32{i[0]}} : $urandom);
      if (i % 3 == 2) check_all();
    end
    check_all();
    // Reset in mid-run must bring every field back to its reset value
    do_reset();
    check_all();
    final_report();
  end
endmodule : tb_top
